// ===== cc_clock_ctrl.sv
// Purpose: Oscillator choice, divider defaults, derived clock rates, timer and clock block 0.
// Assumes: All inputs synchronous to core_clk; straps static around reset.
// Notes: Rates are reported as numbers; the analog loop itself sits outside.
`include "cc_params.svh"

module cc_clock_ctrl
  import cc_pkg::*;
#(
  parameter int unsigned BOOT_WAIT_CLKS = `CC_BOOT_WAIT_CLKS
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic osc_source_select_n,
  input wire logic freq_range_strap_lo,
  input wire logic freq_range_strap_hi,
  input wire logic [31:0] ext_osc_khz,
  input wire logic low_power_mode,
  input wire logic pll_cfg_wr,
  input wire cc_pll_cfg_t pll_cfg_wdata,
  input wire logic port_cb_wr,
  input wire logic [2:0] port_cb_wdata,
  input wire logic cb_src_ext,
  input wire logic [7:0] cb_ref_div,
  input wire logic cb_ext_clk_in,
  input wire logic cb_pin_out_en,
  output logic use_ext_resonator,
  output cc_pll_cfg_t pll_cfg,
  output cc_rates_t rates,
  output logic [31:0] analog_clk_khz,
  output logic [31:0] rtc_clk_hz,
  output logic rtc_on_lowfreq,
  output logic tile_on_main_osc,
  output logic vco_in_range,
  output logic boot_start,
  output logic [31:0] proc_timer,
  output logic [2:0] port_cb_sel,
  output logic cb_clk,
  output logic cb_pin_out,
  output logic cb_pin_oe
);

  // Entire state of the block.
  // Holding it in one struct keeps the reset list and the next-state copy in step.
  typedef struct packed {
    cc_state_t state;
    logic use_ext;
    cc_pll_cfg_t cfg;
    cc_rates_t rates;
    logic [31:0] analog_khz;
    logic [31:0] rtc_hz;
    logic rtc_low;
    logic tile_main;
    logic vco_ok;
    logic [19:0] boot_cnt;
    logic boot;
    logic [31:0] timer;
    logic [2:0] cb_sel;
    logic [7:0] cb_cnt;
    logic cb_clk;
    logic cb_pin;
    logic cb_oe;
  } cc_regs_t;

  // Registered state and its next value.
  cc_regs_t st_ff;
  cc_regs_t nxt_st;

  // Combinational rate values taken from the held settings.
  logic [31:0] osc_khz;
  logic [31:0] fb_p1;
  logic [31:0] in_p1;
  logic [31:0] od_p1;
  logic [31:0] vco_khz;
  logic [31:0] core_khz;
  cc_pll_cfg_t strap_cfg;

  // Boot wait limit sized to the counter.
  // Twenty bits hold the full wait of 750,000 input clocks.
  // The limit is one less because the count starts at zero.
  localparam logic [19:0] BOOT_LAST = 20'(BOOT_WAIT_CLKS - 1);
  localparam logic [31:0] REF_STEP = 32'(`CC_REF_TICKS_PER_CLK);

  // Decode of the range straps into default settings.
  // The result is only caught in the first edge after reset; later changes are ignored.
  // Every code is decoded, so no default branch is needed.
  always_comb
  begin
    // The input divider default is the same for every code.
    strap_cfg.in_div = `CC_IN_DIV_DEF;
    unique case ({freq_range_strap_hi, freq_range_strap_lo})
      `CC_RANGE_00:
      begin
        strap_cfg.out_div = `CC_OD_00;
        strap_cfg.fb = `CC_FB_00;
      end
      `CC_RANGE_11:
      begin
        strap_cfg.out_div = `CC_OD_11;
        strap_cfg.fb = `CC_FB_11;
      end
      `CC_RANGE_10:
      begin
        strap_cfg.out_div = `CC_OD_10;
        strap_cfg.fb = `CC_FB_10;
      end
      `CC_RANGE_01:
      begin
        strap_cfg.out_div = `CC_OD_01;
        strap_cfg.fb = `CC_FB_01;
      end
    endcase
  end

  // Rate arithmetic on the settings now held.
  // The product is halved before the input divider, so integer rounding follows that order.
  // A 100 MHz source times a feedback of 4096 still fits in 32 bits of kHz.
  always_comb
  begin
    // The source caught at reset stands until the next reset.
    // Oscillator rate from the caught source.
    osc_khz = st_ff.use_ext ? ext_osc_khz : `CC_SILICON_OSC_KHZ;
    fb_p1 = {20'h0, st_ff.cfg.fb} + 32'h1;
    in_p1 = {26'h0, st_ff.cfg.in_div} + 32'h1;
    od_p1 = {29'h0, st_ff.cfg.out_div} + 32'h1;
    vco_khz = ((osc_khz * fb_p1) / 32'h2) / in_p1;
    core_khz = vco_khz / od_p1;
  end

  // Next state of the whole block.
  // Edge one after reset catches the straps, edge two takes the first write,
  // and the reported rates follow the settings one edge later.
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff.state)
      CC_ST_RESET:
      begin
        nxt_st.use_ext = ~osc_source_select_n;
        nxt_st.cfg = strap_cfg;
        nxt_st.state = CC_ST_WAIT;
      end
      CC_ST_WAIT:
      begin
        // Boot is raised once and then held while the block runs.
        // Boot wait count.
        if (st_ff.boot_cnt >= BOOT_LAST)
        begin
          nxt_st.boot = 1'b1;
          nxt_st.state = CC_ST_RUN;
        end
        else
        begin
          nxt_st.boot_cnt = st_ff.boot_cnt + 20'h1;
        end
      end
      CC_ST_RUN:
      begin
        // Boot stays set until the next reset.
        nxt_st.boot = 1'b1;
      end
      default:
      begin
        // An illegal state code restarts the sequence.
        nxt_st.state = CC_ST_RESET;
      end
    endcase

    // Writes are not range checked; software keeps the values legal.
    // A write in the strap catching edge is dropped so the defaults always land first.
    // Software rewrite of settings.
    if (pll_cfg_wr && (st_ff.state != CC_ST_RESET))
    begin
      nxt_st.cfg = pll_cfg_wdata;
    end

    // The loop and core rates derive from the one loop output; the reference does not.
    // One loop output feeds the loop and core rates.
    nxt_st.rates.vco_khz = vco_khz;
    nxt_st.rates.core_khz = core_khz;
    // The reference rate is fixed; only the loop and core rates follow software.
    // Reference at its default rate.
    nxt_st.rates.ref_khz = `CC_REF_DEFAULT_KHZ;
    // The flag only reports the window; it does not block a bad setting.
    // Product window reported.
    nxt_st.vco_ok = (vco_khz >= `CC_VCO_MIN_KHZ) && (vco_khz <= `CC_VCO_MAX_KHZ);

    // The analog node bypasses the loop entirely.
    // Analog node rate follows oscillator.
    nxt_st.analog_khz = osc_khz;

    // The main rate is reported in Hz, so the kHz oscillator rate is scaled by a thousand.
    // Low-frequency source in low power.
    nxt_st.rtc_low = low_power_mode;
    // Main oscillator for the tile, and for the counter outside low power.
    nxt_st.rtc_hz = low_power_mode ? `CC_LOWFREQ_OSC_HZ : 32'(osc_khz * 32'd1000);
    nxt_st.tile_main = 1'b1;

    // The timer wraps silently at 32 bits, as a free-running counter should.
    // Free-running timer, 10 ns per count, four counts per edge.
    nxt_st.timer = st_ff.timer + REF_STEP;

    // Ports stay on clock block 0 until software attaches them elsewhere.
    // Port attachment, zero after reset.
    if (port_cb_wr)
    begin
      nxt_st.cb_sel = port_cb_wdata;
    end

    // The divided reference toggles every cb_ref_div plus one edges.
    // The external input is taken as synchronous and is delayed by one edge.
    // Clock block source selection.
    if (cb_src_ext)
    begin
      nxt_st.cb_clk = cb_ext_clk_in;
      nxt_st.cb_cnt = 8'h0;
    end
    else if (st_ff.cb_cnt >= cb_ref_div)
    begin
      nxt_st.cb_clk = ~st_ff.cb_clk;
      nxt_st.cb_cnt = 8'h0;
    end
    else
    begin
      nxt_st.cb_cnt = st_ff.cb_cnt + 8'h1;
    end
    // The pin copy uses the new clock level so that it lines up with cb_clk.
    // Optional drive onto a pin.
    nxt_st.cb_oe = cb_pin_out_en;
    nxt_st.cb_pin = cb_pin_out_en & nxt_st.cb_clk;
  end

  // State register; reset values are constants only.
  // The straps are caught one edge after release rather than here.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff.state <= CC_ST_RESET;
      st_ff.use_ext <= 1'b0;
      st_ff.cfg.out_div <= `CC_OD_00;
      st_ff.cfg.fb <= `CC_FB_00;
      st_ff.cfg.in_div <= `CC_IN_DIV_DEF;
      st_ff.rates.vco_khz <= 32'h0;
      st_ff.rates.core_khz <= 32'h0;
      st_ff.rates.ref_khz <= `CC_REF_DEFAULT_KHZ;
      st_ff.analog_khz <= 32'h0;
      st_ff.rtc_hz <= 32'h0;
      st_ff.rtc_low <= 1'b0;
      st_ff.tile_main <= 1'b1;
      st_ff.vco_ok <= 1'b0;
      st_ff.boot_cnt <= 20'h0;
      st_ff.boot <= 1'b0;
      st_ff.timer <= 32'h0;
      st_ff.cb_sel <= 3'h0;
      st_ff.cb_cnt <= 8'h0;
      st_ff.cb_clk <= 1'b0;
      st_ff.cb_pin <= 1'b0;
      st_ff.cb_oe <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register.
  // No logic sits between the flip-flops and the output ports.
  assign use_ext_resonator = st_ff.use_ext;
  assign pll_cfg = st_ff.cfg;
  assign rates = st_ff.rates;
  assign analog_clk_khz = st_ff.analog_khz;
  assign rtc_clk_hz = st_ff.rtc_hz;
  assign rtc_on_lowfreq = st_ff.rtc_low;
  assign tile_on_main_osc = st_ff.tile_main;
  assign vco_in_range = st_ff.vco_ok;
  assign boot_start = st_ff.boot;
  assign proc_timer = st_ff.timer;
  assign port_cb_sel = st_ff.cb_sel;
  assign cb_clk = st_ff.cb_clk;
  assign cb_pin_out = st_ff.cb_pin;
  assign cb_pin_oe = st_ff.cb_oe;

endmodule : cc_clock_ctrl

// ===== cc_params.svh
// Purpose: Constants for the clock control block.
// Assumes: Included by the clock control module.
// Notes: Frequencies are held in kHz unless the name says otherwise.
`ifndef CC_PARAMS_SVH
`define CC_PARAMS_SVH

// Core clock period and processor reference tick period.
`define CC_CLK_PERIOD_NS 40
`define CC_REF_PERIOD_NS 10
`define CC_REF_TICKS_PER_CLK (`CC_CLK_PERIOD_NS / `CC_REF_PERIOD_NS)
`define CC_REF_DEFAULT_KHZ 32'd100000

// Fixed oscillators.
`define CC_SILICON_OSC_KHZ 32'd20000
`define CC_LOWFREQ_OSC_HZ 32'd31250

// Input clocks to wait after reset before boot.
`define CC_BOOT_WAIT_CLKS 750000

// Strap range codes, hi bit then lo bit.
`define CC_RANGE_00 2'h0
`define CC_RANGE_01 2'h1
`define CC_RANGE_10 2'h2
`define CC_RANGE_11 2'h3

// Default divider settings per range code.
`define CC_OD_00 3'h1
`define CC_FB_00 12'h07a
`define CC_OD_11 3'h2
`define CC_FB_11 12'h077
`define CC_OD_10 3'h2
`define CC_FB_10 12'h031
`define CC_OD_01 3'h2
`define CC_FB_01 12'h017
`define CC_IN_DIV_DEF 6'h00

// Legal window for the product before the output divider.
`define CC_VCO_MIN_KHZ 32'd260000
`define CC_VCO_MAX_KHZ 32'd1300000

`endif

// ===== cc_pkg.sv
// Purpose: Types shared by the clock control block and its users.
// Assumes: Constants come from cc_params.svh.
// Notes: Field widths follow the legal divider ranges.
package cc_pkg;

  // Divider and multiplier settings of the phase-locked loop.
  typedef struct packed {
    logic [2:0] out_div;
    logic [11:0] fb;
    logic [5:0] in_div;
  } cc_pll_cfg_t;

  // Sequencing states.
  typedef enum logic [1:0] {
    CC_ST_RESET = 2'b00,
    CC_ST_WAIT = 2'b01,
    CC_ST_RUN = 2'b10
  } cc_state_t;

  // Derived clock rates, all in kHz.
  typedef struct packed {
    logic [31:0] vco_khz;
    logic [31:0] core_khz;
    logic [31:0] ref_khz;
  } cc_rates_t;

endpackage : cc_pkg

// ===== cc_clock_ctrl_asserts.sv
// Purpose: Port checks for cc_clock_ctrl.
// Assumes: Bound from the bench; one clock domain.
// Notes: Most checks wait three edges after reset.
module cc_clock_ctrl_asserts
  import cc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] ext_osc_khz,
  input wire logic low_power_mode,
  input wire logic pll_cfg_wr,
  input wire cc_pll_cfg_t pll_cfg_wdata,
  input wire logic cb_pin_out_en,
  input wire logic use_ext_resonator,
  input wire cc_pll_cfg_t pll_cfg,
  input wire cc_rates_t rates,
  input wire logic [31:0] analog_clk_khz,
  input wire logic [31:0] rtc_clk_hz,
  input wire logic vco_in_range,
  input wire logic boot_start,
  input wire logic [31:0] proc_timer,
  input wire logic cb_pin_oe
);
  logic [1:0] up_ff;
  // Counts edges since reset so that the settling edges are skipped.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      up_ff <= 2'h0;
    else if (up_ff != 2'h3)
      up_ff <= up_ff + 2'h1;
  end
  default clocking cb_chk @(posedge core_clk); endclocking
  default disable iff (rst);
  // Output relations, each tied to its cause.
  property p_timer; up_ff != 2'h0 |-> proc_timer == $past(proc_timer) + 32'h4; endproperty
  property p_wr; pll_cfg_wr && up_ff == 2'h3 |=> pll_cfg == $past(pll_cfg_wdata); endproperty
  property p_hold; !pll_cfg_wr && up_ff == 2'h3 |=> $stable(pll_cfg); endproperty
  property p_boot; boot_start |=> boot_start [*3]; endproperty
  property p_range; up_ff == 2'h3 |-> vco_in_range ==
    (rates.vco_khz >= 32'h3f7a0 && rates.vco_khz <= 32'h13d620); endproperty
  property p_rtc; up_ff == 2'h3 && $past(low_power_mode) |-> rtc_clk_hz == 32'h7a12; endproperty
  property p_analog; up_ff == 2'h3 |->
    analog_clk_khz == (use_ext_resonator ? $past(ext_osc_khz) : 32'h4e20); endproperty
  property p_oe; up_ff != 2'h0 |-> cb_pin_oe == $past(cb_pin_out_en); endproperty
  a_timer: assert property (p_timer) else $error("timer step wrong");
  a_wr: assert property (p_wr) else $error("write not taken");
  a_hold: assert property (p_hold) else $error("settings moved");
  a_boot: assert property (p_boot) else $error("boot dropped");
  a_range: assert property (p_range) else $error("range flag wrong");
  a_rtc: assert property (p_rtc) else $error("rtc rate wrong");
  a_analog: assert property (p_analog) else $error("analog rate wrong");
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  // Main scenarios seen.
  c_wr2: cover property (pll_cfg_wr ##1 pll_cfg_wr);
  c_boot: cover property ($rose(boot_start));
  c_lp: cover property ($rose(low_power_mode));
endmodule : cc_clock_ctrl_asserts

// ===== cc_osc_model.sv
// Purpose: Board side: oscillator, straps and clock pin.
// Assumes: The bench changes the board setting only with reset.
// Notes: The resonator runs at 12 MHz.
module cc_osc_model
(
  input wire logic core_clk,
  input wire logic [2:0] board_cfg,
  output logic osc_source_select_n,
  output logic freq_range_strap_lo,
  output logic freq_range_strap_hi,
  output logic [31:0] ext_osc_khz,
  output logic cb_ext_clk_in
);
  logic [1:0] ph_ff = 2'h0;
  assign {osc_source_select_n, freq_range_strap_hi, freq_range_strap_lo} = board_cfg;
  assign ext_osc_khz = 32'h2ee0;
  assign cb_ext_clk_in = ph_ff[1];
  // External clock on the pin, a quarter of core_clk.
  always @(posedge core_clk)
    ph_ff <= ph_ff + 2'h1;
endmodule : cc_osc_model

// ===== cc_clock_ctrl_bench.sv
// Purpose: Self-checking bench for cc_clock_ctrl.
// Assumes: Boot wait shortened to 16 edges.
// Notes: Inputs move 1 ns after each rising edge.
module cc_clock_ctrl_bench
  import cc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned BW = 16;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] board_cfg = 3'h0;
  logic low_power_mode = 1'b0, pll_cfg_wr = 1'b0, port_cb_wr = 1'b0;
  logic cb_src_ext = 1'b0, cb_pin_out_en = 1'b0;
  logic [2:0] port_cb_wdata = 3'h0, port_cb_sel;
  logic [7:0] cb_ref_div = 8'h2;
  cc_pll_cfg_t pll_cfg_wdata = '0, pll_cfg;
  cc_rates_t rates;
  logic osc_source_select_n, freq_range_strap_lo, freq_range_strap_hi, cb_ext_clk_in;
  logic use_ext_resonator, rtc_on_lowfreq, tile_on_main_osc, vco_in_range, boot_start;
  logic cb_clk, cb_pin_out, cb_pin_oe;
  logic [31:0] ext_osc_khz, analog_clk_khz, rtc_clk_hz, proc_timer, t0, osc;
  int fails = 0, samples_checked = 0, n;
  cc_pll_cfg_t tbl [4] = '{'{3'h1, 12'h07a, 6'h0}, '{3'h2, 12'h017, 6'h0},
    '{3'h2, 12'h031, 6'h0}, '{3'h2, 12'h077, 6'h0}};
  always #20 core_clk = ~core_clk;
  cc_osc_model u_osc (.core_clk, .board_cfg, .osc_source_select_n, .freq_range_strap_lo,
    .freq_range_strap_hi, .ext_osc_khz, .cb_ext_clk_in);
  cc_clock_ctrl #(.BOOT_WAIT_CLKS(BW)) dut (.core_clk, .rst, .osc_source_select_n,
    .freq_range_strap_lo, .freq_range_strap_hi, .ext_osc_khz, .low_power_mode, .pll_cfg_wr,
    .pll_cfg_wdata, .port_cb_wr, .port_cb_wdata, .cb_src_ext, .cb_ref_div, .cb_ext_clk_in,
    .cb_pin_out_en, .use_ext_resonator, .pll_cfg, .rates, .analog_clk_khz, .rtc_clk_hz,
    .rtc_on_lowfreq, .tile_on_main_osc, .vco_in_range, .boot_start, .proc_timer,
    .port_cb_sel, .cb_clk, .cb_pin_out, .cb_pin_oe);
  // Compares one result and counts it.
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick
  // Resets with one board setting and times the start of boot.
  task automatic boot(input logic [2:0] bc);
    board_cfg = bc;
    rst = 1'b1;
    tick(12);
    rst = 1'b0;
    n = 0;
    while (boot_start !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk("boot edge", BW + 1, n);
  endtask : boot
  function automatic logic [31:0] core_of(input cc_pll_cfg_t c, input logic [31:0] f);
    return f * (c.fb + 32'h1) / 32'h2 / (c.in_div + 32'h1) / (c.out_div + 32'h1);
  endfunction : core_of
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  // Main sequence of tests.
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      boot(i[2:0]);
      osc = i[2] ? 32'h4e20 : 32'h2ee0;
      chk("cfg", 32'(tbl[i % 4]), 32'(pll_cfg));
      chk("use_ext", {31'h0, !i[2]}, {31'h0, use_ext_resonator});
      chk("core", core_of(tbl[i % 4], osc), rates.core_khz);
      chk("ref", 32'h186a0, rates.ref_khz);
      chk("analog", osc, analog_clk_khz);
      chk("tile osc", 32'h1, {31'h0, tile_on_main_osc});
      chk("port sel", 32'h0, {29'h0, port_cb_sel});
    end
    $display("strap tests done");
    pll_cfg_wdata = '{3'h7, 12'hfff, 6'h3f};
    pll_cfg_wr = 1'b1;
    tick(1);
    chk("cfg w1", 32'h001fffff, 32'(pll_cfg));
    pll_cfg_wdata = '{3'h0, 12'h0ff, 6'h0};
    tick(1);
    pll_cfg_wr = 1'b0;
    chk("cfg w2", 32'h00003fc0, 32'(pll_cfg));
    chk("core w1", 32'h13880, rates.core_khz);
    chk("range w1", 32'h1, {31'h0, vco_in_range});
    chk("vco w1", 32'h9c400, rates.vco_khz);
    tick(1);
    chk("core w2", 32'h271000, rates.core_khz);
    chk("range w2", 32'h0, {31'h0, vco_in_range});
    $display("write tests done");
    port_cb_wdata = 3'h5;
    port_cb_wr = 1'b1;
    tick(1);
    port_cb_wr = 1'b0;
    chk("port sel", 32'h5, {29'h0, port_cb_sel});
    for (int k = 0; k < 2; k++)
    begin
      t0[0] = cb_clk;
      n = 0;
      while (cb_clk === t0[0] && n < 9)
      begin
        tick(1);
        n++;
      end
    end
    chk("cb half", 32'h3, n);
    cb_src_ext = 1'b1;
    cb_pin_out_en = 1'b1;
    tick(2);
    for (int k = 0; k < 4; k++)
    begin
      t0 = {31'h0, cb_ext_clk_in};
      tick(1);
      chk("cb ext", t0, {31'h0, cb_clk});
      chk("cb pin", t0, {31'h0, cb_pin_out});
    end
    chk("pin oe", 32'h1, {31'h0, cb_pin_oe});
    $display("clock block tests done");
    low_power_mode = 1'b1;
    tick(2);
    chk("rtc lp", 32'h7a12, rtc_clk_hz);
    chk("rtc src", 32'h1, {31'h0, rtc_on_lowfreq});
    low_power_mode = 1'b0;
    tick(2);
    chk("rtc main", 32'h1312d00, rtc_clk_hz);
    t0 = proc_timer;
    tick(10);
    chk("timer", t0 + 32'h28, proc_timer);
    $display("rtc and timer tests done");
    complete_run();
  end
  // Cuts a hang short.
  initial
  begin
    #100000;
    fails++;
    complete_run();
  end
endmodule : cc_clock_ctrl_bench
bind cc_clock_ctrl cc_clock_ctrl_asserts u_chk (.core_clk, .rst, .ext_osc_khz, .low_power_mode,
  .pll_cfg_wr, .pll_cfg_wdata, .cb_pin_out_en, .use_ext_resonator, .pll_cfg, .rates,
  .analog_clk_khz, .rtc_clk_hz, .vco_in_range, .boot_start, .proc_timer, .cb_pin_oe);
